// *** core/rstack_pkg.sv ***
package rstack_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned DEPTH = 16;
  localparam int unsigned PTR_W = 4;
  localparam int unsigned PC_W  = 16;

  // ----------------------------------------------------------------
  // reset values and pointer landmarks
  // ----------------------------------------------------------------
  localparam logic [PTR_W-1:0] PTR_RESET   = 4'h0;
  localparam logic [PTR_W-1:0] PTR_TOP     = 4'hF;
  localparam logic [PTR_W-1:0] PTR_STEP    = 4'h1;
  localparam logic [PC_W-1:0]  ENTRY_RESET = 16'h0000;
  localparam logic [PC_W-1:0]  PC_RESET    = 16'h0000;
  localparam logic             FLAG_RESET  = 1'h1;

  // ----------------------------------------------------------------
  // sequencer requests
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE       = 3'h0,
    OP_CALL       = 3'h1,
    OP_IRQ_VECTOR = 3'h2,
    OP_RETURN     = 3'h3,
    OP_RET_LIT    = 3'h4,
    OP_RET_IRQ    = 3'h5
  } stack_op_t;

  // stack space flag states, one-hot
  typedef enum logic [2:0] {
    SPACE_FREE   = 3'h1,
    SPACE_TOP    = 3'h2,
    SPACE_LOCKED = 3'h4
  } space_state_t;

  typedef struct packed {
    logic            valid;
    stack_op_t       op;
    logic [PC_W-1:0] pc;
  } stack_req_t;

  typedef struct packed {
    logic            valid;
    logic [PC_W-1:0] pc;
  } stack_rsp_t;

endpackage : rstack_pkg

// *** core/stack_store.sv ***
module stack_store
(
  input  wire logic                         mclk,
  input  wire logic                         rst_b,
  input  wire logic                         wrEn,
  input  wire logic [rstack_pkg::PTR_W-1:0] wrIdx,
  input  wire logic [rstack_pkg::PC_W-1:0]  wrData,
  input  wire logic [rstack_pkg::PTR_W-1:0] rdIdx,
  output logic      [rstack_pkg::PC_W-1:0]  rdData
);

  // ----------------------------------------------------------------
  // entry flops, one process per entry
  // ----------------------------------------------------------------
  logic [rstack_pkg::PC_W-1:0] entry_q [rstack_pkg::DEPTH];

  genvar g;
  generate
    for (g = 0; g < rstack_pkg::DEPTH; g++)
    begin : gEntry
      // index cut to pointer width on purpose
      localparam logic [rstack_pkg::PTR_W-1:0] ENTRY_IDX = rstack_pkg::PTR_W'(g);
      wire hit = wrEn && (wrIdx == ENTRY_IDX);

      // oldest entry simply gets overwritten once the ring is full
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
          entry_q[g] <= rstack_pkg::ENTRY_RESET;
        else if (hit)
          entry_q[g] <= wrData;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read port, indexed combinationally
  // ----------------------------------------------------------------
  assign rdData = entry_q[rdIdx];

endmodule : stack_store

// *** core/circular_return_stack.sv ***
module circular_return_stack
(
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  input  wire rstack_pkg::stack_req_t req,
  output rstack_pkg::stack_rsp_t      rsp,
  output logic                        stackSpaceFlag
);

  // ----------------------------------------------------------------
  // request decoding
  // ----------------------------------------------------------------

  // call or interrupt vectoring saves the pc
  function automatic logic isPush(input rstack_pkg::stack_req_t r);
    isPush = r.valid && (r.op == rstack_pkg::OP_CALL ||
                         r.op == rstack_pkg::OP_IRQ_VECTOR);
  endfunction : isPush

  // all three return flavours restore the pc
  function automatic logic isPop(input rstack_pkg::stack_req_t r);
    isPop = r.valid && (r.op == rstack_pkg::OP_RETURN ||
                        r.op == rstack_pkg::OP_RET_LIT ||
                        r.op == rstack_pkg::OP_RET_IRQ);
  endfunction : isPop

  wire pushReq = isPush(req);
  wire popReq  = isPop(req);

  // ----------------------------------------------------------------
  // pointer
  // ----------------------------------------------------------------
  logic [rstack_pkg::PTR_W-1:0] ptr_q;
  logic [rstack_pkg::PTR_W-1:0] ptr_d;
  wire  [rstack_pkg::PTR_W-1:0] ptrInc = ptr_q + rstack_pkg::PTR_STEP;
  wire  [rstack_pkg::PTR_W-1:0] ptrDec = ptr_q - rstack_pkg::PTR_STEP;

  // 4-bit arithmetic wraps by itself, giving the ring
  assign ptr_d = pushReq ? ptrInc :
                 popReq  ? ptrDec :
                 ptr_q;

  // no software path reaches the pointer at all
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      ptr_q <= rstack_pkg::PTR_RESET;
    else
      ptr_q <= ptr_d;
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [rstack_pkg::PC_W-1:0] rdData;

  // write at the old pointer, read at the decremented one
  stack_store uStore
  (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .wrEn   (pushReq),
    .wrIdx  (ptr_q),
    .wrData (req.pc),
    .rdIdx  (ptrDec),
    .rdData (rdData)
  );

  // ----------------------------------------------------------------
  // pop answer
  // ----------------------------------------------------------------
  // the answer feeds only the pc; the high latch has no path here
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rsp.valid <= 1'h0;
      rsp.pc    <= rstack_pkg::PC_RESET;
    end
    else
    begin
      rsp.valid <= popReq;
      if (popReq)
        rsp.pc <= rdData;
    end
  end

  // ----------------------------------------------------------------
  // stack space flag state machine
  // ----------------------------------------------------------------
  rstack_pkg::space_state_t space_q;
  rstack_pkg::space_state_t space_d;

  wire wrapUp  = pushReq && (ptr_q == rstack_pkg::PTR_TOP);
  wire atTop_d = (ptr_d == rstack_pkg::PTR_TOP);

  // a pop from zero lands on top, so underflow reads as full
  always_comb
  begin
    space_d = space_q;
    case (space_q)
      rstack_pkg::SPACE_FREE,
      rstack_pkg::SPACE_TOP:
      begin
        if (wrapUp)
          space_d = rstack_pkg::SPACE_LOCKED;
        else if (atTop_d)
          space_d = rstack_pkg::SPACE_TOP;
        else
          space_d = rstack_pkg::SPACE_FREE;
      end
      rstack_pkg::SPACE_LOCKED:
        space_d = rstack_pkg::SPACE_LOCKED;
      default:
        space_d = rstack_pkg::SPACE_LOCKED;
    endcase
  end

  // only reset leaves the locked state
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      space_q <= rstack_pkg::SPACE_FREE;
    else
      space_q <= space_d;
  end

  // flag as a flop so it never glitches toward the core
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      stackSpaceFlag <= rstack_pkg::FLAG_RESET;
    else
      stackSpaceFlag <= (space_d == rstack_pkg::SPACE_FREE);
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  logic [rstack_pkg::PTR_W-1:0] ptrCk;
  assign ptrCk = ptr_q;

  // ----------------------------------------------------------------
  // pointer checks
  // ----------------------------------------------------------------

  // push steps the pointer up by one
  push_step_a: assert property (
    pushReq |=> ptr_q == $past(ptrInc))
    else $error("push did not advance the pointer");

  // pop steps the pointer down by one
  pop_step_a: assert property (
    popReq |=> ptr_q == $past(ptrDec))
    else $error("pop did not retreat the pointer");

  // pointer holds with no request
  ptr_hold_a: assert property (
    !pushReq && !popReq |=> $stable(ptr_q))
    else $error("pointer moved without a request");

  // ----------------------------------------------------------------
  // flag and answer checks
  // ----------------------------------------------------------------

  // flag low whenever pointer is at top
  top_clear_a: assert property (
    ptr_q == rstack_pkg::PTR_TOP |-> !stackSpaceFlag)
    else $error("flag set while pointer at top");

  // wrap from top locks the flag clear
  wrap_lock_a: assert property (
    wrapUp |=> (space_q == rstack_pkg::SPACE_LOCKED) && !stackSpaceFlag)
    else $error("wrap did not lock the flag");

  // once locked, stays clear
  lock_hold_a: assert property (
    space_q == rstack_pkg::SPACE_LOCKED |=> !stackSpaceFlag [*3])
    else $error("locked flag came back");

  // pop from empty lands on top with flag clear
  underflow_a: assert property (
    popReq && ptr_q == rstack_pkg::PTR_RESET
      |=> ptr_q == rstack_pkg::PTR_TOP && !stackSpaceFlag)
    else $error("underflow not shown as full");

  // a call followed by a return gives back the saved pc
  call_ret_a: assert property (
    pushReq ##1 popReq |=> rsp.valid && rsp.pc == $past(req.pc, 2))
    else $error("returned pc differs from pushed pc");

  // answer pulses exactly one cycle after a pop
  answer_time_a: assert property (
    rsp.valid |-> $past(popReq))
    else $error("answer without a pop");

  // flag high only when free and off the top
  flag_free_a: assert property (
    stackSpaceFlag |-> space_q == rstack_pkg::SPACE_FREE && ptrCk != rstack_pkg::PTR_TOP)
    else $error("flag high outside free state");

  // ----------------------------------------------------------------
  // storage checks
  // ----------------------------------------------------------------

  // the entry below the pointer is the one just pushed
  push_write_a: assert property (
    pushReq |=> rdData == $past(req.pc))
    else $error("pushed pc not stored below the pointer");

  // entries and pointer rest with no request
  store_hold_a: assert property (
    !pushReq && !popReq |=> $stable(rdData))
    else $error("stored entry moved without a request");

  // ----------------------------------------------------------------
  // ignored code and answer checks
  // ----------------------------------------------------------------

  // codes outside push and pop move nothing
  ignore_op_a: assert property (
    req.valid && !pushReq && !popReq |=> $stable(ptr_q) && !rsp.valid)
    else $error("ignored code changed the stack");

  // every pop gets its answer one cycle later
  pop_answer_a: assert property (
    popReq |=> rsp.valid)
    else $error("pop gave no answer");

  // no answer pulse without a pop
  no_answer_a: assert property (
    !popReq |=> !rsp.valid)
    else $error("answer pulse without a pop");

  // last popped pc stands until the next pop
  pc_hold_a: assert property (
    !popReq |=> $stable(rsp.pc))
    else $error("answer pc changed without a pop");

  // ----------------------------------------------------------------
  // pointer wrap and flag state checks
  // ----------------------------------------------------------------

  // push at the top wraps the pointer to zero
  ptr_wrap_a: assert property (
    pushReq && ptr_q == rstack_pkg::PTR_TOP |=> ptr_q == rstack_pkg::PTR_RESET)
    else $error("push at top did not wrap to zero");

  // free state always shows the flag set
  free_flag_a: assert property (
    space_q == rstack_pkg::SPACE_FREE |-> stackSpaceFlag)
    else $error("flag clear in free state");

  // top state only with the pointer at fifteen
  top_state_a: assert property (
    space_q == rstack_pkg::SPACE_TOP |-> ptr_q == rstack_pkg::PTR_TOP)
    else $error("top state off the top entry");

  // landing on fifteen clears the flag next cycle
  top_land_a: assert property (
    atTop_d && !wrapUp |=> !stackSpaceFlag)
    else $error("flag set after landing on top");

  // unlocked pop from the top gives space back
  top_leave_a: assert property (
    space_q == rstack_pkg::SPACE_TOP && popReq |=> stackSpaceFlag)
    else $error("flag stayed clear after leaving top");

  // locked state never shows the flag
  lock_flag_a: assert property (
    space_q == rstack_pkg::SPACE_LOCKED |-> !stackSpaceFlag)
    else $error("flag set in locked state");

  // only reset leaves the locked state
  lock_sticky_a: assert property (
    space_q == rstack_pkg::SPACE_LOCKED |=> space_q == rstack_pkg::SPACE_LOCKED)
    else $error("locked state left without reset");

  // push right after an underflowing pop locks the flag
  under_lock_a: assert property (
    popReq && ptr_q == rstack_pkg::PTR_RESET ##1 pushReq
      |=> space_q == rstack_pkg::SPACE_LOCKED && !stackSpaceFlag)
    else $error("push after underflow did not lock");

  // a broken state code falls to the locked state through the default branch
  space_code_a: assert property (
    $onehot(space_q))
    else $error("flag state code not one-hot");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------

  ignore_cover: cover property (req.valid && !pushReq && !popReq);
  wrap_cover: cover property (wrapUp);
  underflow_cover: cover property (popReq && ptr_q == rstack_pkg::PTR_RESET ##1 pushReq);
  call_ret_cover: cover property (pushReq ##1 popReq);
  top_cover: cover property (ptr_q == rstack_pkg::PTR_TOP && popReq);

endmodule : circular_return_stack

// *** bench/seq_model.sv ***
module seq_model
(
  input  wire logic              mclk,
  output rstack_pkg::stack_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // sequencer requests
  // ----------------------------------------------------------------
  initial req = '0;

  // one request per call; chained calls give back-to-back traffic
  task automatic issue(input rstack_pkg::stack_op_t op, input logic [15:0] pc);
    @(posedge mclk);
    req <= '{valid: 1'h1, op: op, pc: pc};
  endtask : issue

  // idle: pc keeps changing so a stale value is never mistaken for data
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      req <= '{valid: 1'h0, op: rstack_pkg::OP_NONE, pc: ~req.pc};
    end
  endtask : idle
endmodule : seq_model

// *** bench/circular_return_stack_tb.sv ***
module circular_return_stack_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   mclk;
  logic                   rst_b;
  rstack_pkg::stack_req_t req;
  rstack_pkg::stack_rsp_t rsp;
  logic                   stackSpaceFlag;
  int                     miscompares;
  int                     checked;

`define CHK(what, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("FAIL %s exp %0h got %0h", what, exp, got); \
    end \
  end

  // ----------------------------------------------------------------
  // clock, design and sequencer
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  circular_return_stack u_dut (.mclk(mclk), .rst_b(rst_b), .req(req), .rsp(rsp),
                               .stackSpaceFlag(stackSpaceFlag));
  seq_model u_seq (.mclk(mclk), .req(req));

  // ----------------------------------------------------------------
  // shared steps
  // ----------------------------------------------------------------
  task automatic reset_dut();
    @(posedge mclk);
    rst_b <= 1'h0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'h1;
  endtask : reset_dut

  // pushes alternate call and interrupt so both codes are exercised
  task automatic push_n(input logic [15:0] base, input int n);
    for (int i = 0; i < n; i++)
      u_seq.issue(i[0] ? rstack_pkg::OP_IRQ_VECTOR : rstack_pkg::OP_CALL, base + 16'(i));
    u_seq.idle(1);
    #1;
  endtask : push_n

  task automatic pop_chk(input rstack_pkg::stack_op_t op, input logic [15:0] exp,
                         input logic flag);
    u_seq.issue(op, 16'h0000);
    u_seq.idle(1);
    #1;
    `CHK("pop valid", 1'h1, rsp.valid)
    `CHK("pop pc", exp, rsp.pc)
    `CHK("space flag", flag, stackSpaceFlag)
  endtask : pop_chk

  task automatic test_done();
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_lifo();
    #1;
    `CHK("flag after reset", 1'h1, stackSpaceFlag)
    push_n(16'hA000, 2);
    pop_chk(rstack_pkg::OP_RETURN, 16'hA001, 1'h1);
    pop_chk(rstack_pkg::OP_RET_LIT, 16'hA000, 1'h1);
    u_seq.idle(1);
    #1;
    `CHK("valid pulse", 1'h0, rsp.valid)
    `CHK("pc held", 16'hA000, rsp.pc)
    push_n(16'hB000, 1);
    pop_chk(rstack_pkg::OP_RET_IRQ, 16'hB000, 1'h1);
  endtask : t_lifo

  // 14 pushes keep space, the 15th clears it; stale pointer would clear early
  task automatic t_fifteen();
    reset_dut();
    push_n(16'h1000, 3);
    reset_dut();
    push_n(16'h2000, 14);
    `CHK("flag at 14", 1'h1, stackSpaceFlag)
    push_n(16'h200E, 1);
    `CHK("flag at 15", 1'h0, stackSpaceFlag)
    pop_chk(rstack_pkg::OP_RETURN, 16'h200E, 1'h1);
  endtask : t_fifteen

  task automatic t_wrap();
    reset_dut();
    push_n(16'h3000, 17);
    `CHK("flag wrapped", 1'h0, stackSpaceFlag)
    pop_chk(rstack_pkg::OP_RET_IRQ, 16'h3010, 1'h0);
    pop_chk(rstack_pkg::OP_RETURN, 16'h300F, 1'h0);
    pop_chk(rstack_pkg::OP_RET_LIT, 16'h300E, 1'h0);
  endtask : t_wrap

  // pop from empty, then push locks; pop-pop alone does not
  task automatic t_under();
    reset_dut();
    pop_chk(rstack_pkg::OP_RETURN, 16'h0000, 1'h0);
    push_n(16'h4000, 1);
    `CHK("flag locked", 1'h0, stackSpaceFlag)
    pop_chk(rstack_pkg::OP_RETURN, 16'h4000, 1'h0);
    pop_chk(rstack_pkg::OP_RETURN, 16'h0000, 1'h0);
    reset_dut();
    pop_chk(rstack_pkg::OP_RETURN, 16'h0000, 1'h0);
    pop_chk(rstack_pkg::OP_RET_LIT, 16'h0000, 1'h1);
  endtask : t_under

  // back to back: pop from empty, push, pop; then codes that must be ignored
  task automatic t_b2b();
    reset_dut();
    u_seq.issue(rstack_pkg::OP_RETURN, 16'h0000);
    u_seq.issue(rstack_pkg::OP_CALL, 16'h5000);
    u_seq.issue(rstack_pkg::OP_RET_IRQ, 16'h0000);
    u_seq.idle(1);
    #1;
    `CHK("b2b valid", 1'h1, rsp.valid)
    `CHK("b2b pc", 16'h5000, rsp.pc)
    `CHK("b2b lock", 1'h0, stackSpaceFlag)
    u_seq.issue(rstack_pkg::OP_NONE, 16'h6000);
    u_seq.issue(rstack_pkg::stack_op_t'(3'h6), 16'h6001);
    u_seq.idle(1);
    #1;
    `CHK("ignored op", 1'h0, rsp.valid)
    pop_chk(rstack_pkg::OP_RETURN, 16'h0000, 1'h0);
  endtask : t_b2b

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    rst_b = 1'h0;
    miscompares = 0;
    checked = 0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'h1;
    t_lifo();
    t_fifteen();
    t_wrap();
    t_under();
    t_b2b();
    test_done();
  end

  // whole run is about a hundred cycles; this bound is generous
  initial
  begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    test_done();
  end
endmodule : circular_return_stack_tb
